// File: hdl/pakirq_pkg.sv
package pakirq_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] OFS_PULL_ENABLE = 8'h00;
  localparam logic [7:0] OFS_SLEW_RATE_ENABLE = 8'h04;
  localparam logic [7:0] OFS_DRIVE_STRENGTH_SELECT = 8'h08;
  localparam logic [7:0] OFS_PIN_IRQ_STATUS_CONTROL = 8'h0c;
  localparam logic [7:0] OFS_PIN_IRQ_SELECT = 8'h10;
  localparam logic [7:0] OFS_PIN_IRQ_POLARITY = 8'h14;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h18;
  localparam logic [7:0] OFS_EVENT_MASK = 8'h1c;
  localparam logic [7:0] OFS_PIN_LEVEL = 8'h20;

  // Field positions in the status and control register
  localparam int POS_DETECT_MODE = 0;
  localparam int POS_PORT_IRQ_ENABLE = 1;
  localparam int POS_PORT_IRQ_ACKNOWLEDGE = 2;
  localparam int POS_PORT_IRQ_FLAG = 3;

  // Port geometry
  localparam int NUM_PINS = 6;
  localparam int NUM_DRIVE_PINS = 5;
  localparam int NUM_IRQ_PINS = 4;
  localparam int OPEN_DRAIN_PIN_FIVE = 5;

  // Values after reset
  localparam logic [5:0] RST_PULL_ENABLE = 6'h00;
  localparam logic [4:0] RST_SLEW_RATE_ENABLE = 5'h00;
  localparam logic [4:0] RST_DRIVE_STRENGTH_SELECT = 5'h00;
  localparam logic [3:0] RST_PIN_IRQ_SELECT = 4'h0;
  localparam logic [3:0] RST_PIN_IRQ_POLARITY = 4'h0;
  localparam logic [3:0] RST_EVENT_STATUS = 4'h0;
  localparam logic [3:0] RST_EVENT_MASK = 4'h0;
  localparam logic [3:0] RST_PIN_SYNC = 4'h0;

  // Pad control bundle driven to the pin cells
  typedef struct packed {
    logic [5:0] pull_on;
    logic [5:0] pull_down;
    logic [4:0] slew_on;
    logic [4:0] high_drive;
  } pakirq_pad_t;

  // Stored part of the status and control register
  typedef struct packed {
    logic port_irq_flag;
    logic port_irq_enable;
    logic detect_mode;
  } pakirq_sc_t;

  localparam pakirq_pad_t RST_PAD = '0;
  localparam pakirq_sc_t RST_SC = '0;

  // APB slave phases, Gray coded along idle, setup, access
  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_SETUP = 2'b01,
    APB_ACCESS = 2'b11
  } pakirq_apb_state_t;

endpackage

// File: hdl/pakirq_port.sv
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/100ps
// Summary of operation
// - Each of pins 5 to 0 has a pull-enable bit, 1 turning its pull device on and 0 off.
// - Except on open-drain pin 5, the pull device is off whenever the pin is an output.
// - A pull-down replaces the pull-up only on a selected interrupt pin whose polarity is rising or high.
// - Pins 4 to 0 have slew control enables, 1 enabling, with no effect on inputs.
// - Bit 5 of the slew and drive registers is reserved, ignores writes and reads as zero here.
// - Pins 4 to 0 have drive strength bits, 0 low and 1 high, with no effect on inputs.
// - The port interrupt flag in status bit 3 is set on detection and ignores writes to bit 3.
// - Writing 1 to acknowledge bit 2 clears the flag unless a detection occurs or mode 1 sees a selected pin at its active level; bit 2 reads as 0.
// - The port interrupt request is raised only while enable bit 1 is 1.
// - Mode bit 0 picks edge-only detection at 0 and edge plus level detection at 1.
// - Only pins 3 to 0 whose select bit is 1 can cause a port interrupt.
// - Polarity 0 attaches a pull-up and makes a falling edge or low level active.
// - Polarity 1 attaches a pull-down on a selected pin and makes a rising edge or high level active.
module pakirq_port
  import pakirq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] pin_is_output,
  input wire logic [3:0] pin_in,
  output pakirq_pad_t pad_ctrl,
  output logic port_irq_request,
  output logic irq
);

  pakirq_apb_state_t apb_state;
  pakirq_apb_state_t next_apb_state;
  pakirq_sc_t sc;
  logic port_irq_flag;
  logic port_irq_enable;
  logic detect_mode;
  pakirq_pad_t next_pad_ctrl;
  logic [5:0] pull_enable;
  logic [4:0] slew_rate_enable;
  logic [4:0] drive_strength_select;
  logic [3:0] pin_irq_select;
  logic [3:0] pin_irq_polarity;
  logic [3:0] event_status;
  logic [3:0] event_mask;
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [3:0] pin_prev;
  logic [3:0] pin_active;
  logic [3:0] pin_edge;
  logic [3:0] pin_detect;
  logic level_hold;
  logic any_detect;
  logic addr_hit;
  logic wr_take;
  logic wr_lane0;
  logic ack_write;
  logic [31:0] next_rdata;

  // Bus phase tracker; only used to keep read data aligned with the access
  always_comb
  begin
    next_apb_state = apb_state;
    case (apb_state)
      APB_IDLE:
      begin
        if (psel)
          next_apb_state = APB_SETUP;
      end
      APB_SETUP:
      begin
        if (psel && penable)
          next_apb_state = APB_ACCESS;
        else if (!psel)
          next_apb_state = APB_IDLE;
      end
      APB_ACCESS:
      begin
        if (psel && !penable)
          next_apb_state = APB_SETUP;
        else if (!psel)
          next_apb_state = APB_IDLE;
      end
      default:
      begin
        next_apb_state = APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      apb_state <= APB_IDLE;
    else
      apb_state <= next_apb_state;
  end

  // Address decode over the nine mapped words
  always_comb
  begin
    case (paddr)
      OFS_PULL_ENABLE,
      OFS_SLEW_RATE_ENABLE,
      OFS_DRIVE_STRENGTH_SELECT,
      OFS_PIN_IRQ_STATUS_CONTROL,
      OFS_PIN_IRQ_SELECT,
      OFS_PIN_IRQ_POLARITY,
      OFS_EVENT_STATUS,
      OFS_EVENT_MASK,
      OFS_PIN_LEVEL:
        addr_hit = 1'b1;
      default:
        addr_hit = 1'b0;
    endcase
  end

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  // All fields live in byte lane 0, so a write without that lane stores nothing
  assign wr_take = psel && penable && pwrite && addr_hit;
  assign wr_lane0 = wr_take && pstrb[0];
  assign ack_write = wr_lane0 && (paddr == OFS_PIN_IRQ_STATUS_CONTROL) && pwdata[POS_PORT_IRQ_ACKNOWLEDGE];

  // Read mux, evaluated during setup
  always_comb
  begin
    next_rdata = 32'h00000000;
    case (paddr)
      OFS_PULL_ENABLE:
        next_rdata[5:0] = pull_enable;
      OFS_SLEW_RATE_ENABLE:
        next_rdata[4:0] = slew_rate_enable;
      OFS_DRIVE_STRENGTH_SELECT:
        next_rdata[4:0] = drive_strength_select;
      OFS_PIN_IRQ_STATUS_CONTROL:
      begin
        next_rdata[POS_PORT_IRQ_FLAG] = sc.port_irq_flag;
        next_rdata[POS_PORT_IRQ_ACKNOWLEDGE] = 1'b0;
        next_rdata[POS_PORT_IRQ_ENABLE] = sc.port_irq_enable;
        next_rdata[POS_DETECT_MODE] = sc.detect_mode;
      end
      OFS_PIN_IRQ_SELECT:
        next_rdata[3:0] = pin_irq_select;
      OFS_PIN_IRQ_POLARITY:
        next_rdata[3:0] = pin_irq_polarity;
      OFS_EVENT_STATUS:
        next_rdata[3:0] = event_status;
      OFS_EVENT_MASK:
        next_rdata[3:0] = event_mask;
      OFS_PIN_LEVEL:
        next_rdata[3:0] = pin_sync;
      default:
        next_rdata = 32'h00000000;
    endcase
  end

  // Read data is captured in setup so it is stable through the access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if ((next_apb_state == APB_SETUP) && !pwrite)
      prdata <= next_rdata;
  end

  // Pad configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pull_enable <= RST_PULL_ENABLE;
      slew_rate_enable <= RST_SLEW_RATE_ENABLE;
      drive_strength_select <= RST_DRIVE_STRENGTH_SELECT;
    end
    else if (wr_lane0)
    begin
      if (paddr == OFS_PULL_ENABLE)
        pull_enable <= pwdata[5:0];
      if (paddr == OFS_SLEW_RATE_ENABLE)
        slew_rate_enable <= pwdata[4:0];
      if (paddr == OFS_DRIVE_STRENGTH_SELECT)
        drive_strength_select <= pwdata[4:0];
    end
  end

  // Interrupt pin configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_irq_select <= RST_PIN_IRQ_SELECT;
      pin_irq_polarity <= RST_PIN_IRQ_POLARITY;
      event_mask <= RST_EVENT_MASK;
    end
    else if (wr_lane0)
    begin
      if (paddr == OFS_PIN_IRQ_SELECT)
        pin_irq_select <= pwdata[3:0];
      if (paddr == OFS_PIN_IRQ_POLARITY)
        pin_irq_polarity <= pwdata[3:0];
      if (paddr == OFS_EVENT_MASK)
        event_mask <= pwdata[3:0];
    end
  end

  // Enable and mode bits; the flag is left to its own process
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_irq_enable <= RST_SC.port_irq_enable;
      detect_mode <= RST_SC.detect_mode;
    end
    else if (wr_lane0 && (paddr == OFS_PIN_IRQ_STATUS_CONTROL))
    begin
      port_irq_enable <= pwdata[POS_PORT_IRQ_ENABLE];
      detect_mode <= pwdata[POS_DETECT_MODE];
    end
  end

  // Two-stage synchroniser, the first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= RST_PIN_SYNC;
      pin_sync <= RST_PIN_SYNC;
      pin_prev <= RST_PIN_SYNC;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Per-pin detection; a polarity change can look like an edge, hence the init order
  always_comb
  begin
    for (int i = 0; i < NUM_IRQ_PINS; i++)
    begin
      pin_active[i] = pin_irq_polarity[i] ? pin_sync[i] : !pin_sync[i];
      pin_edge[i] = pin_irq_polarity[i] ? (pin_sync[i] && !pin_prev[i]) : (!pin_sync[i] && pin_prev[i]);
      pin_detect[i] = pin_irq_select[i] && (pin_edge[i] || (sc.detect_mode && pin_active[i]));
    end
  end

  assign any_detect = |pin_detect;
  // In mode 1, a selected pin still at its active level blocks the acknowledge
  assign level_hold = sc.detect_mode && |(pin_irq_select & pin_active);

  // Flag: set wins over acknowledge, plain writes never touch it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port_irq_flag <= RST_SC.port_irq_flag;
    else if (any_detect)
      port_irq_flag <= 1'b1;
    else if (ack_write && !level_hold)
      port_irq_flag <= 1'b0;
  end

  // Per-pin sticky events, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      event_status <= RST_EVENT_STATUS;
    else if (wr_lane0 && (paddr == OFS_EVENT_STATUS))
      event_status <= (event_status & ~pwdata[3:0]) | pin_detect;
    else
      event_status <= event_status | pin_detect;
  end

  // Pad control; pin 5 is open drain and keeps its pull as an output
  always_comb
  begin
    next_pad_ctrl = RST_PAD;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (i == OPEN_DRAIN_PIN_FIVE)
        next_pad_ctrl.pull_on[i] = pull_enable[i];
      else
        next_pad_ctrl.pull_on[i] = pull_enable[i] && !pin_is_output[i];
    end
    for (int i = 0; i < NUM_IRQ_PINS; i++)
    begin
      next_pad_ctrl.pull_down[i] = pin_irq_select[i] && pin_irq_polarity[i];
    end
    for (int i = 0; i < NUM_DRIVE_PINS; i++)
    begin
      next_pad_ctrl.slew_on[i] = slew_rate_enable[i] && pin_is_output[i];
      next_pad_ctrl.high_drive[i] = drive_strength_select[i] && pin_is_output[i];
    end
  end

  // Registered so the pad cells see glitch-free controls
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pad_ctrl <= RST_PAD;
    else
      pad_ctrl <= next_pad_ctrl;
  end

  // Status fields gathered in one word; each bit keeps its own register and driver
  assign sc = {port_irq_flag, port_irq_enable, detect_mode};

  // Request and summary interrupt outputs
  assign port_irq_request = sc.port_irq_flag && sc.port_irq_enable;
  assign irq = |(event_status & event_mask);

endmodule

// File: testbench/pakirq_monitor.sv
`timescale 1ns/100ps
module pakirq_monitor
  import pakirq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [5:0] pin_is_output,
  input wire pakirq_pad_t pad_ctrl,
  input wire logic port_irq_request
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Pad bundle follows the direction seen one edge earlier
  a_pull_out: assert property ((pad_ctrl.pull_on[4:0] & $past(pin_is_output[4:0])) == 5'h00)
    else $error("pull left on an output pin");
  a_slew_in: assert property ((pad_ctrl.slew_on & ~$past(pin_is_output[4:0])) == 5'h00)
    else $error("slew control on an input pin");
  a_drive_in: assert property ((pad_ctrl.high_drive & ~$past(pin_is_output[4:0])) == 5'h00)
    else $error("high drive on an input pin");
  a_pdown_hi: assert property (pad_ctrl.pull_down[5:4] == 2'b00)
    else $error("pull-down on a pin without interrupt");
  // Read data checks in the access cycle
  a_rsvd_zero: assert property (psel && penable && !pwrite && (paddr == 8'h04 || paddr == 8'h08)
    |-> prdata[31:5] == 27'h0)
    else $error("reserved bit reads one");
  a_ack_zero: assert property (psel && penable && !pwrite && paddr == 8'h0c |-> !prdata[2])
    else $error("acknowledge bit reads one");
  // The request only drops after a register write
  a_req_hold: assert property ($fell(port_irq_request) |-> $past(psel && penable && pwrite))
    else $error("request dropped without a write");
  a_unmap_err: assert property (psel && penable && paddr > 8'h20 && paddr[1:0] == 2'b00 |-> pslverr)
    else $error("no error on unmapped address");
endmodule

bind pakirq_port pakirq_monitor pakirq_monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pslverr, .pin_is_output, .pad_ctrl, .port_irq_request);

// File: testbench/pakirq_pins.sv
`timescale 1ns/100ps
module pakirq_pins
  import pakirq_pkg::*;
(
  input wire logic pclk,
  input wire pakirq_pad_t pad_ctrl,
  input wire logic [3:0] drv_en,
  input wire logic [3:0] drv_val,
  output logic [3:0] pin_in
);
  logic [3:0] drift = 4'h5;
  // Unpulled released pins wander, so no level is assumed
  always_ff @(posedge pclk)
  begin
    drift <= ~drift;
  end
  // Board drive wins, then the pad's pull device
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (drv_en[i])
        pin_in[i] = drv_val[i];
      else if (pad_ctrl.pull_on[i])
        pin_in[i] = ~pad_ctrl.pull_down[i];
      else
        pin_in[i] = drift[i];
    end
  end
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import pakirq_pkg::*;
();
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, port_irq_request, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0] pstrb, pin_in, drv_en, drv_val;
  logic [5:0] pin_is_output;
  pakirq_pad_t pad_ctrl;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  pakirq_port pakirq_port_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .pin_is_output, .pin_in, .pad_ctrl, .port_irq_request, .irq);
  pakirq_pins pakirq_pins_inst (.pclk, .pad_ctrl, .drv_en, .drv_val, .pin_in);
  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Cut a hang short
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, idle edge after it so the next may start cleanly
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rv, e);
  endtask
  // Reset values, unmapped read
  task automatic t_reset();
    for (int a = 0; a <= 32; a += 4)
      rdc(8'(a), 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    check({err, rv[30:0]}, 32'h80000000);
  endtask
  // Field widths, reserved bits, read-only flag
  task automatic t_regs();
    logic [7:0] a[5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14};
    logic [31:0] m[5] = '{32'h3f, 32'h1f, 32'h1f, 32'hf, 32'hf};
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, a[i], 32'hffffffff);
      rdc(a[i], m[i]);
      apb(1'b1, a[i], 32'h0);
    end
    pstrb <= 4'he;
    apb(1'b1, 8'h00, 32'h3f);
    pstrb <= 4'hf;
    rdc(8'h00, 32'h0);
    apb(1'b1, 8'h0c, 32'hff);
    rdc(8'h0c, 32'h03);
    apb(1'b1, 8'h0c, 32'h0);
  endtask
  // Pad controls against direction and interrupt setup
  task automatic t_pads();
    apb(1'b1, 8'h00, 32'h3f);
    apb(1'b1, 8'h04, 32'h1f);
    apb(1'b1, 8'h08, 32'h1f);
    pin_is_output <= 6'h3f;
    repeat (2) @(posedge pclk);
    check(32'(pad_ctrl), {10'h0, 6'h20, 6'h00, 5'h1f, 5'h1f});
    pin_is_output <= 6'h00;
    apb(1'b1, 8'h10, 32'h5);
    apb(1'b1, 8'h14, 32'h3);
    @(posedge pclk);
    check(32'(pad_ctrl), {10'h0, 6'h3f, 6'h01, 10'h0});
  endtask
  // Edge mode: select, polarity, flag, ack, enable, events
  task automatic t_edge();
    drv_en <= 4'h3;
    drv_val <= 4'h3;
    apb(1'b1, 8'h0c, 32'h0);
    apb(1'b1, 8'h14, 32'h0);
    apb(1'b1, 8'h00, 32'h0f);
    apb(1'b1, 8'h10, 32'h1);
    apb(1'b1, 8'h0c, 32'h4);
    apb(1'b1, 8'h0c, 32'h2);
    apb(1'b1, 8'h18, 32'hf);
    apb(1'b1, 8'h1c, 32'h1);
    drv_val <= 4'h1;
    repeat (5) @(posedge pclk);
    check({31'h0, port_irq_request}, 32'h0);
    drv_val <= 4'h0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check({31'h0, port_irq_request}, 32'h0);
    @(negedge pclk);
    check({30'h0, port_irq_request, irq}, 32'h3);
    @(posedge pclk);
    apb(1'b1, 8'h0c, 32'h0a);
    rdc(8'h0c, 32'h0a);
    apb(1'b1, 8'h0c, 32'h06);
    rdc(8'h0c, 32'h02);
    rdc(8'h18, 32'h1);
    apb(1'b1, 8'h1c, 32'h0);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h18, 32'h1);
    rdc(8'h18, 32'h0);
    apb(1'b1, 8'h0c, 32'h0);
    drv_val <= 4'h1;
    repeat (4) @(posedge pclk);
    rdc(8'h0c, 32'h0);
    drv_val <= 4'h0;
    repeat (4) @(posedge pclk);
    check({31'h0, port_irq_request}, 32'h0);
    rdc(8'h0c, 32'h08);
    apb(1'b1, 8'h0c, 32'h06);
  endtask
  // Level mode on a high-active pin
  task automatic t_level();
    apb(1'b1, 8'h0c, 32'h0);
    apb(1'b1, 8'h14, 32'h4);
    apb(1'b1, 8'h10, 32'h4);
    drv_en <= 4'h4;
    apb(1'b1, 8'h0c, 32'h07);
    rdc(8'h0c, 32'h03);
    drv_val <= 4'h4;
    repeat (4) @(posedge pclk);
    apb(1'b1, 8'h0c, 32'h07);
    rdc(8'h0c, 32'h0b);
    apb(1'b1, 8'h0c, 32'h02);
    rdc(8'h0c, 32'h0a);
    apb(1'b1, 8'h0c, 32'h06);
    rdc(8'h0c, 32'h02);
    apb(1'b1, 8'h0c, 32'h03);
    rdc(8'h0c, 32'h0b);
    drv_val <= 4'h0;
    repeat (4) @(posedge pclk);
    apb(1'b1, 8'h0c, 32'h07);
    rdc(8'h0c, 32'h03);
  endtask
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, drv_val, pin_is_output} = '0;
    pstrb = 4'hf;
    drv_en = 4'hf;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_regs();
    t_pads();
    t_edge();
    t_level();
    finish_test();
  end
endmodule
